// ### rtl/ecfb_pkg.sv
// package: constants and types for the exception cause flag bank
package ecfb_pkg;

    // register map
    localparam logic [7:0]  ECFB_FLAGS_OFS   = 8'h00;
    localparam logic [31:0] ECFB_FLAGS_RST   = 32'h0000_0000;

    // flag bit positions
    localparam int          ECFB_BIT_ILL     = 20;
    localparam int          ECFB_BIT_DACC    = 19;
    localparam int          ECFB_BIT_IACC    = 18;
    localparam int          ECFB_BIT_DMISS   = 17;
    localparam int          ECFB_BIT_IMISS   = 16;
    localparam int          ECFB_BIT_DBG     = 15;
    localparam int          ECFB_BIT_RSV     = 14;
    localparam int          ECFB_BIT_DBLF    = 13;
    localparam int          ECFB_BIT_BUSF    = 12;

    // bits that hold state, and bits that a software write may clear
    localparam logic [31:0] ECFB_LIVE_MASK   = 32'h001f_b000;
    localparam logic [31:0] ECFB_SWCLR_MASK  = 32'h001f_3000;

    // reset synchroniser depth
    localparam int          ECFB_RST_STAGES  = 2;

    // origin of a bus error reported by the bus interface
    typedef enum logic [1:0] {
        ECFB_BK_FETCH    = 2'b00,
        ECFB_BK_DREAD    = 2'b01,
        ECFB_BK_CTRL_WR  = 2'b10,
        ECFB_BK_OTHER_WR = 2'b11
    } ecfb_bus_kind_t;

    // exception events from the core, one-cycle pulses
    typedef struct packed {
        logic           illegal_fetch;
        logic           data_xlate_access;
        logic           instr_xlate_access;
        logic           data_xlate_miss;
        logic           instr_xlate_miss;
        logic           debugger_irq;
        logic           nonrecov_sync_irq;
        logic           irq_entry_busy;
        logic           bus_error;
        ecfb_bus_kind_t bus_kind;
    } ecfb_evt_t;

endpackage : ecfb_pkg

// ### rtl/ecfb_flag_bank.sv
// module: exception cause flag bank, bits 20 down to 12
//
// Contract
// - an illegal instruction access event sets bit 20.
// - a data translation access event sets bit 19.
// - an instruction translation access event sets bit 18.
// - a data translation miss event sets bit 17.
// - an instruction translation miss event sets bit 16.
// - an interrupt of the debugger-reserved group sets bit 15.
// - software writes leave bit 15 unchanged.
// - bit 15 clears only when the debug facility clears all flags at once.
// - bit 14 is reserved, always reads zero, and software writes only zero.
// - a nonrecoverable synchronous interrupt during interrupt entry sets bit 13.
// - a synchronous bus error during a bus access sets bit 12.
// - only bus errors that would stall the processor count as synchronous.
// - fetch, data read and control space write errors are synchronous.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module ecfb_flag_bank
    import ecfb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // events from the core
    input  wire ecfb_evt_t         evt,
    input  wire logic              dbg_clear_all,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    // flag state
    output logic      [31:0]       flags,
    output logic                   sync_bus_fault
);

    logic [ECFB_RST_STAGES-1:0] rst_pipe;
    logic                       rst_ok;
    logic [31:0]                flag;
    logic [31:0]                next_flag;
    logic [31:0]                set_vec;
    logic [31:0]                keep_vec;
    logic [31:0]                wr_keep;
    logic [31:0]                dbg_keep;
    logic [31:0]                next_rdata;
    logic                       wr_hit;
    logic                       rd_hit;
    logic                       bus_sync;
    logic                       dbl_fault;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= '0;
        end else begin
            rst_pipe <= {rst_pipe[ECFB_RST_STAGES-2:0], 1'b1};
        end
    end

    assign rst_ok = rst_pipe[ECFB_RST_STAGES-1];

    // register decode
    assign wr_hit = wr && (addr == ADDR_W'(ECFB_FLAGS_OFS));
    assign rd_hit = rd && (addr == ADDR_W'(ECFB_FLAGS_OFS));

    // bus errors that stall the core; other writes are posted and ignored
    assign bus_sync = evt.bus_error &&
                      ((evt.bus_kind == ECFB_BK_FETCH) ||
                       (evt.bus_kind == ECFB_BK_DREAD) ||
                       (evt.bus_kind == ECFB_BK_CTRL_WR));

    assign dbl_fault = evt.nonrecov_sync_irq && evt.irq_entry_busy;

    // event set vector
    always_comb begin
        set_vec                 = '0;
        set_vec[ECFB_BIT_ILL]   = evt.illegal_fetch;
        set_vec[ECFB_BIT_DACC]  = evt.data_xlate_access;
        set_vec[ECFB_BIT_IACC]  = evt.instr_xlate_access;
        set_vec[ECFB_BIT_DMISS] = evt.data_xlate_miss;
        set_vec[ECFB_BIT_IMISS] = evt.instr_xlate_miss;
        set_vec[ECFB_BIT_DBG]   = evt.debugger_irq;
        set_vec[ECFB_BIT_DBLF]  = dbl_fault;
        set_vec[ECFB_BIT_BUSF]  = bus_sync;
    end

    // a write of zero clears a bit; the debugger flag is outside the write mask
    assign wr_keep   = wr_hit ? (wdata | ~ECFB_SWCLR_MASK) : '1;
    assign dbg_keep  = dbg_clear_all ? '0 : '1;
    assign keep_vec  = wr_keep & dbg_keep;

    // set wins over any clear in the same cycle; reserved bit forced low
    assign next_flag = ((flag & keep_vec) | set_vec) & ECFB_LIVE_MASK;

    // read data stands only in the cycle after the read strobe
    assign next_rdata = rd_hit ? (flag & ECFB_LIVE_MASK) : '0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= ECFB_FLAGS_RST;
        end else if (!rst_ok) begin
            flag <= ECFB_FLAGS_RST;
        end else begin
            flag <= next_flag;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata          <= '0;
            sync_bus_fault <= 1'b0;
        end else begin
            rdata          <= rst_ok ? next_rdata : '0;
            sync_bus_fault <= rst_ok && bus_sync;
        end
    end

    assign flags = flag;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_ok);

    logic rst_ok_d;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ok_d <= 1'b0;
        end else begin
            rst_ok_d <= rst_ok;
        end
    end

    chk_ill_set: assert property (evt.illegal_fetch |=> flag[ECFB_BIT_ILL])
        else $error("illegal fetch flag not set");

    chk_dacc_set: assert property (evt.data_xlate_access |=> flag[ECFB_BIT_DACC])
        else $error("data translation access flag not set");

    chk_iacc_set: assert property (evt.instr_xlate_access |=> flag[ECFB_BIT_IACC])
        else $error("instruction translation access flag not set");

    chk_dmiss_set: assert property (evt.data_xlate_miss |=> flag[ECFB_BIT_DMISS])
        else $error("data translation miss flag not set");

    chk_imiss_set: assert property (evt.instr_xlate_miss |=> flag[ECFB_BIT_IMISS])
        else $error("instruction translation miss flag not set");

    chk_dbg_irq_set: assert property (evt.debugger_irq |=> flag[ECFB_BIT_DBG])
        else $error("debugger interrupt flag not set");

    chk_dbg_write_held: assert property (
        (wr_hit && !dbg_clear_all && !evt.debugger_irq && rst_ok_d)
        |=> (flag[ECFB_BIT_DBG] == $past(flag[ECFB_BIT_DBG])))
        else $error("write changed debugger interrupt flag");

    chk_dbg_clear_all: assert property (
        (dbg_clear_all && (set_vec == '0)) |=> (flag == '0) ##1 (rdata == '0 || !$past(rd_hit)))
        else $error("clear-all left a flag set");

    chk_dbg_only_by_all: assert property (
        (flag[ECFB_BIT_DBG] && !dbg_clear_all) |=> flag[ECFB_BIT_DBG])
        else $error("debugger interrupt flag lost without clear-all");

    chk_rsv_zero: assert property (
        !flag[ECFB_BIT_RSV] && !rdata[ECFB_BIT_RSV] && (flags & ~ECFB_LIVE_MASK) == '0)
        else $error("reserved bit or unused bit reads one");

    chk_dbl_fault: assert property (
        (evt.nonrecov_sync_irq && evt.irq_entry_busy) |=> flag[ECFB_BIT_DBLF])
        else $error("double fault flag not set");

    chk_dbl_needs_entry: assert property (
        (!flag[ECFB_BIT_DBLF] && !evt.irq_entry_busy) |=> !flag[ECFB_BIT_DBLF])
        else $error("double fault flag set outside interrupt entry");

    chk_bus_sync_set: assert property (
        (evt.bus_error && evt.bus_kind != ECFB_BK_OTHER_WR)
        |=> (flag[ECFB_BIT_BUSF] && sync_bus_fault))
        else $error("synchronous bus error not recorded");

    chk_bus_async_skip: assert property (
        (!flag[ECFB_BIT_BUSF] && (!evt.bus_error || evt.bus_kind == ECFB_BK_OTHER_WR))
        |=> (!flag[ECFB_BIT_BUSF] && !sync_bus_fault))
        else $error("posted write bus error recorded");

    chk_bus_ctrl_wr: assert property (
        (evt.bus_error && evt.bus_kind == ECFB_BK_CTRL_WR) |=> flag[ECFB_BIT_BUSF])
        else $error("control space write error not synchronous");

    chk_sw_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_ILL] && !evt.illegal_fetch) |=> !flag[ECFB_BIT_ILL])
        else $error("write of zero did not clear flag");

    chk_sticky: assert property (
        (flag[ECFB_BIT_DACC] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_DACC]))
        |=> flag[ECFB_BIT_DACC][*2] or (flag[ECFB_BIT_DACC] ##1 1'b1))
        else $error("flag dropped without clear");

    chk_read_data: assert property (
        rd_hit |=> (rdata == ($past(flag) & ECFB_LIVE_MASK)) ##1 ($past(rd_hit) || rdata == '0))
        else $error("read data wrong or not one cycle");

    chk_rdata_idle: assert property (
        !rd_hit |=> (rdata == '0))
        else $error("read data not zero without a read");

    chk_reset_clear: assert property (
        !rst_ok_d |-> (flag == ECFB_FLAGS_RST && rdata == '0))
        else $error("flags or read data not clear after reset");

    chk_sbf_pulse: assert property (
        !evt.bus_error |=> !sync_bus_fault)
        else $error("bus fault pulse without a bus error");

    chk_ill_no_spur: assert property (
        (!flag[ECFB_BIT_ILL] && !evt.illegal_fetch) |=> !flag[ECFB_BIT_ILL])
        else $error("illegal fetch flag set without event");

    chk_dacc_no_spur: assert property (
        (!flag[ECFB_BIT_DACC] && !evt.data_xlate_access) |=> !flag[ECFB_BIT_DACC])
        else $error("data access flag set without event");

    chk_iacc_no_spur: assert property (
        (!flag[ECFB_BIT_IACC] && !evt.instr_xlate_access) |=> !flag[ECFB_BIT_IACC])
        else $error("instruction access flag set without event");

    chk_dmiss_no_spur: assert property (
        (!flag[ECFB_BIT_DMISS] && !evt.data_xlate_miss) |=> !flag[ECFB_BIT_DMISS])
        else $error("data miss flag set without event");

    chk_imiss_no_spur: assert property (
        (!flag[ECFB_BIT_IMISS] && !evt.instr_xlate_miss) |=> !flag[ECFB_BIT_IMISS])
        else $error("instruction miss flag set without event");

    chk_dbg_no_spur: assert property (
        (!flag[ECFB_BIT_DBG] && !evt.debugger_irq) |=> !flag[ECFB_BIT_DBG])
        else $error("debugger interrupt flag set without event");

    chk_dacc_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_DACC] && !evt.data_xlate_access) |=> !flag[ECFB_BIT_DACC])
        else $error("write of zero did not clear data access flag");

    chk_iacc_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_IACC] && !evt.instr_xlate_access) |=> !flag[ECFB_BIT_IACC])
        else $error("write of zero did not clear instruction access flag");

    chk_dmiss_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_DMISS] && !evt.data_xlate_miss) |=> !flag[ECFB_BIT_DMISS])
        else $error("write of zero did not clear data miss flag");

    chk_imiss_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_IMISS] && !evt.instr_xlate_miss) |=> !flag[ECFB_BIT_IMISS])
        else $error("write of zero did not clear instruction miss flag");

    chk_dblf_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_DBLF] && !(evt.nonrecov_sync_irq && evt.irq_entry_busy))
        |=> !flag[ECFB_BIT_DBLF])
        else $error("write of zero did not clear double fault flag");

    chk_busf_clear: assert property (
        (wr_hit && !wdata[ECFB_BIT_BUSF] && !evt.bus_error)
        |=> !flag[ECFB_BIT_BUSF])
        else $error("write of zero did not clear bus fault flag");

    chk_ill_sticky: assert property (
        (flag[ECFB_BIT_ILL] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_ILL]))
        |=> flag[ECFB_BIT_ILL])
        else $error("illegal fetch flag dropped without clear");

    chk_iacc_sticky: assert property (
        (flag[ECFB_BIT_IACC] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_IACC]))
        |=> flag[ECFB_BIT_IACC])
        else $error("instruction access flag dropped without clear");

    chk_dmiss_sticky: assert property (
        (flag[ECFB_BIT_DMISS] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_DMISS]))
        |=> flag[ECFB_BIT_DMISS])
        else $error("data miss flag dropped without clear");

    chk_imiss_sticky: assert property (
        (flag[ECFB_BIT_IMISS] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_IMISS]))
        |=> flag[ECFB_BIT_IMISS])
        else $error("instruction miss flag dropped without clear");

    chk_dblf_sticky: assert property (
        (flag[ECFB_BIT_DBLF] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_DBLF]))
        |=> flag[ECFB_BIT_DBLF])
        else $error("double fault flag dropped without clear");

    chk_busf_sticky: assert property (
        (flag[ECFB_BIT_BUSF] && !dbg_clear_all && !(wr_hit && !wdata[ECFB_BIT_BUSF]))
        |=> flag[ECFB_BIT_BUSF])
        else $error("bus fault flag dropped without clear");

    cov_ill_then_clear: cover property (
        evt.illegal_fetch ##1 (wr_hit && !wdata[ECFB_BIT_ILL]) ##1 !flag[ECFB_BIT_ILL]);

    cov_set_beats_clear: cover property (
        (wr_hit && !wdata[ECFB_BIT_DMISS] && evt.data_xlate_miss) ##1 flag[ECFB_BIT_DMISS]);

    cov_dbg_clear_all: cover property (
        flag[ECFB_BIT_DBG] ##1 dbg_clear_all ##1 !flag[ECFB_BIT_DBG]);

    cov_double_fault: cover property (
        (evt.nonrecov_sync_irq && evt.irq_entry_busy) ##1 rd_hit ##1 rdata[ECFB_BIT_DBLF]);

endmodule : ecfb_flag_bank

`default_nettype wire

// ### tb/ecfb_core_model.sv
// core exception source model: turns a bench event code into one event word
`timescale 1ns/10ps
`default_nettype none

module ecfb_core_model
    import ecfb_pkg::*;
(
    // event code, 0 for none, 13 for entry busy alone
    input  wire logic [3:0] code,
    // event word to the flag bank
    output var  ecfb_evt_t  evt
);
    always_comb begin
        evt                    = '0;
        evt.illegal_fetch      = (code == 4'h1);
        evt.data_xlate_access  = (code == 4'h2);
        evt.instr_xlate_access = (code == 4'h3);
        evt.data_xlate_miss    = (code == 4'h4);
        evt.instr_xlate_miss   = (code == 4'h5);
        evt.debugger_irq       = (code == 4'h6);
        evt.nonrecov_sync_irq  = (code == 4'h7) || (code == 4'h8);
        evt.irq_entry_busy     = (code == 4'h7) || (code == 4'hd);
        evt.bus_error          = (code >= 4'h9) && (code <= 4'hc);
        // codes 9..12 give fetch, data read, control write, posted write
        evt.bus_kind = ecfb_bus_kind_t'(code[1:0] - 2'h1);
    end
endmodule : ecfb_core_model

`default_nettype wire

// ### tb/tb_exception_cause_flag_bank.sv
// testbench for the exception cause flag bank
`timescale 1ns/10ps
`default_nettype none

module tb_exception_cause_flag_bank
    import ecfb_pkg::*;
();
    typedef struct packed {
        logic [3:0]  code;
        logic [31:0] flags;
        logic        sbf;
    } ecfb_row_t;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  code = 4'h0;
    logic        clr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] flags;
    logic        sync_bus_fault;
    ecfb_evt_t   evt;
    int          n_mismatch = 0;
    int          check_count = 0;
    ecfb_row_t   rows [13] = '{
        '{4'h1, 32'h0010_0000, 1'b0}, '{4'h2, 32'h0008_0000, 1'b0},
        '{4'h3, 32'h0004_0000, 1'b0}, '{4'h4, 32'h0002_0000, 1'b0},
        '{4'h5, 32'h0001_0000, 1'b0}, '{4'h6, 32'h0000_8000, 1'b0},
        '{4'h7, 32'h0000_2000, 1'b0}, '{4'h8, 32'h0000_0000, 1'b0},
        '{4'h9, 32'h0000_1000, 1'b1}, '{4'ha, 32'h0000_1000, 1'b1},
        '{4'hb, 32'h0000_1000, 1'b1}, '{4'hc, 32'h0000_0000, 1'b0},
        '{4'hd, 32'h0000_0000, 1'b0}};

    always #4 clk = ~clk;

    ecfb_core_model core (.code(code), .evt(evt));
    ecfb_flag_bank DUT (.clk(clk), .rst_n(rst_n), .evt(evt), .dbg_clear_all(clr),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .flags(flags),
        .sync_bus_fault(sync_bus_fault));

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp32

    task automatic cmp1(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : cmp1

    task automatic fire(input logic [3:0] k);
        @(posedge clk) code <= k;
        @(posedge clk) code <= 4'h0;
        #1;
    endtask : fire

    task automatic pulse_clr();
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
    endtask : pulse_clr

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin
            wr <= 1'b1;
            addr <= a;
            wdata <= d;
        end
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) begin
            rd <= 1'b1;
            addr <= a;
        end
        @(posedge clk) rd <= 1'b0;
        #1 cmp32(rdata, exp, "read data");
    endtask : bus_rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 cmp32(flags, 32'h0, "flags after reset");
        bus_rd(ECFB_FLAGS_OFS, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            pulse_clr();
            fire(rows[i].code);
            cmp1(sync_bus_fault, rows[i].sbf, "bus fault pulse");
            cmp32(flags, rows[i].flags, "event flag");
            bus_rd(ECFB_FLAGS_OFS, rows[i].flags);
        end
        $display("test event rows done");
        pulse_clr();
        for (int k = 1; k <= 7; k++) fire(4'(k));
        repeat (5) @(posedge clk);
        #1 cmp32(flags, 32'h001f_a000, "sticky flags");
        bus_wr(8'h04, 32'h0);
        cmp32(flags, 32'h001f_a000, "unmapped write");
        bus_rd(8'h04, 32'h0);
        bus_wr(ECFB_FLAGS_OFS, 32'hffff_bfff);
        cmp32(flags, 32'h001f_a000, "write of ones");
        bus_wr(ECFB_FLAGS_OFS, 32'h0);
        cmp32(flags, 32'h0000_8000, "write of zero");
        pulse_clr();
        #1 cmp32(flags, 32'h0, "debug clear all");
        $display("test clear paths done");
        @(posedge clk) begin
            code <= 4'h4;
            clr  <= 1'b1;
        end
        @(posedge clk) begin
            code <= 4'h0;
            clr  <= 1'b0;
        end
        #1 cmp32(flags, 32'h0002_0000, "set beats clear-all");
        @(posedge clk) begin
            code  <= 4'h1;
            wr    <= 1'b1;
            addr  <= ECFB_FLAGS_OFS;
            wdata <= 32'h0;
        end
        @(posedge clk) begin
            code <= 4'h0;
            wr   <= 1'b0;
        end
        #1 cmp32(flags, 32'h0010_0000, "set beats write clear");
        $display("test set wins done");
        fire(4'h1);
        @(posedge clk) rst_n <= 1'b0;
        #1 cmp32(flags, 32'h0, "mid-run reset");
        repeat (2) @(posedge clk);
        @(posedge clk) begin
            rst_n <= 1'b1;
            code  <= 4'h2;
        end
        @(posedge clk) code <= 4'h0;
        repeat (3) @(posedge clk);
        #1 cmp32(flags, 32'h0, "event during reset settle");
        fire(4'h5);
        cmp32(flags, 32'h0001_0000, "event after second reset");
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : tb_exception_cause_flag_bank

`default_nettype wire
